/* core/sdr_drop_report.sv */
// Drop event reporting: port 2 rate drop counter, interrupt mask, pending slots
`timescale 1ns/1ps
`include "sdr_params.svh"
//==============================================================================

module sdr_drop_report
   import sdr_pkg::*;
#(
   parameter int unsigned CNT_W = `SDR_CNT_W
)
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   input  wire logic       i_clk_en,
   input  wire sdr_bus_s   i_bus,
   input  wire sdr_event_s i_drop,
   output logic [31:0]     o_rd_data,
   output logic            o_irq
);

   //===========================================================================
   // Functions

   // Address match against one register offset
   function automatic logic addr_hit
   (
      input logic [`SDR_ADDR_W-1:0] addr,
      input logic [`SDR_ADDR_W-1:0] ofs
   );
      return addr == ofs;
   endfunction

   // Only documented reason codes are recorded
   function automatic logic reason_ok
   (
      input logic [3:0] rsn
   );
      logic ok;
      ok = 1'b0;
      case (rsn)
         SDR_RSN_BCAST_LEVEL : ok = 1'b1;
         SDR_RSN_RED         : ok = 1'b1;
         SDR_RSN_NO_BUF      : ok = 1'b1;
         SDR_RSN_NO_DESC     : ok = 1'b1;
         SDR_RSN_NO_DEST     : ok = 1'b1;
         SDR_RSN_RX_ERR      : ok = 1'b1;
         SDR_RSN_DROP_LEVEL  : ok = 1'b1;
         SDR_RSN_YELLOW      : ok = 1'b1;
         default             : ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Reserved source port code is never recorded
   function automatic logic port_ok
   (
      input logic [1:0] prt
   );
      return prt != SDR_PORT_RSVD;
   endfunction

   // Saturating increment
   function automatic logic [CNT_W-1:0] sat_inc
   (
      input logic [CNT_W-1:0] val
   );
      logic [CNT_W-1:0] res;
      res = val;
      if (&val)
      begin
         res = val;
      end
      else
      begin
         res = val + 1'b1;
      end
      return res;
   endfunction

   // Fill state implied by the valid flags of both slots
   function automatic sdr_fill_e fill_from_slots
   (
      input sdr_slot_s sa,
      input sdr_slot_s sb
   );
      sdr_fill_e f;
      f = SDR_FILL_EMPTY;
      if (sa.valid && sb.valid)
      begin
         f = SDR_FILL_AB;
      end
      else if (sa.valid)
      begin
         f = SDR_FILL_A;
      end
      return f;
   endfunction

   // Place both slots into the pending register layout
   function automatic logic [31:0] pack_pending
   (
      input sdr_slot_s sa,
      input sdr_slot_s sb
   );
      logic [31:0] word;
      word = 32'h00000000;
      word[`SDR_A_VALID_BIT]                           = sa.valid;
      word[`SDR_A_PORT_LSB +: 2]                       = sa.port;
      word[`SDR_A_REASON_LSB +: 4]                     = sa.reason;
      word[`SDR_B_VALID_BIT]                           = sb.valid;
      word[`SDR_B_PORT_LSB +: 2]                       = sb.port;
      word[`SDR_B_REASON_LSB +: 4]                     = sb.reason;
      return word;
   endfunction

   //===========================================================================
   // Declarations

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic             mask_r;
   logic             mask_nxt;
   sdr_fill_e        fill_r;
   sdr_fill_e        fill_nxt;
   sdr_slot_s        slot_a_r;
   sdr_slot_s        slot_a_nxt;
   sdr_slot_s        slot_b_r;
   sdr_slot_s        slot_b_nxt;
   logic [31:0]      rd_data_r;
   logic [31:0]      rd_data_nxt;
   logic             irq_r;
   logic             irq_nxt;

   logic             rd_cnt;
   logic             rd_pend;
   logic             rd_mask;
   logic             wr_mask;
   logic             ev_ok;
   logic             rate_hit;
   sdr_slot_s        ev_slot;

   //===========================================================================
   // Register bus decode

   always_comb
   begin
      rd_cnt  = 1'b0;
      rd_pend = 1'b0;
      rd_mask = 1'b0;
      wr_mask = 1'b0;
      if (i_bus.rd && addr_hit(i_bus.addr, `SDR_OFS_P2_CNT))
      begin
         rd_cnt = 1'b1;
      end
      else if (i_bus.rd && addr_hit(i_bus.addr, `SDR_OFS_PEND))
      begin
         rd_pend = 1'b1;
      end
      else if (i_bus.rd && addr_hit(i_bus.addr, `SDR_OFS_MASK))
      begin
         rd_mask = 1'b1;
      end
      if (i_bus.wr && addr_hit(i_bus.addr, `SDR_OFS_MASK))
      begin
         wr_mask = 1'b1;
      end
   end

   //===========================================================================
   // Drop event qualification

   always_comb
   begin
      ev_ok          = i_drop.valid && reason_ok(i_drop.reason) && port_ok(i_drop.port);
      ev_slot.valid  = 1'b1;
      ev_slot.reason = i_drop.reason;
      ev_slot.port   = i_drop.port;
      rate_hit       = ev_ok && (i_drop.port == SDR_PORT2) &&
                       ((i_drop.reason == SDR_RSN_RED) ||
                        (i_drop.reason == SDR_RSN_YELLOW));
   end

   //===========================================================================
   // Port 2 rate drop counter

   always_comb
   begin
      cnt_nxt = cnt_r;
      if (rd_cnt)
      begin
         cnt_nxt = '0;
      end
      if (rate_hit)
      begin
         cnt_nxt = sat_inc(cnt_nxt);
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_r <= CNT_W'(`SDR_RST_P2_CNT);
      end
      else if (i_clk_en)
      begin
         cnt_r <= cnt_nxt;
      end
   end

   //===========================================================================
   // Interrupt mask

   always_comb
   begin
      mask_nxt = mask_r;
      if (wr_mask)
      begin
         mask_nxt = i_bus.wdata[`SDR_MASK_BIT];
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         mask_r <= `SDR_RST_MASK;
      end
      else if (i_clk_en)
      begin
         mask_r <= mask_nxt;
      end
   end

   //===========================================================================
   // Pending record slots

   always_comb
   begin
      sdr_fill_e base;
      base       = fill_r;
      slot_a_nxt = slot_a_r;
      slot_b_nxt = slot_b_r;
      // Illegal fill code is rebuilt from the slot valid flags
      case (fill_r)
         SDR_FILL_EMPTY, SDR_FILL_A, SDR_FILL_AB :
         begin
            base = fill_r;
         end
         default :
         begin
            base = fill_from_slots(slot_a_r, slot_b_r);
         end
      endcase
      if (rd_pend)
      begin
         base       = SDR_FILL_EMPTY;
         slot_a_nxt = '0;
         slot_b_nxt = '0;
      end
      fill_nxt = base;
      if (ev_ok)
      begin
         case (base)
            SDR_FILL_EMPTY :
            begin
               slot_a_nxt = ev_slot;
               fill_nxt   = SDR_FILL_A;
            end
            SDR_FILL_A :
            begin
               slot_b_nxt = ev_slot;
               fill_nxt   = SDR_FILL_AB;
            end
            SDR_FILL_AB :
            begin
               fill_nxt   = SDR_FILL_AB;
            end
            default :
            begin
               slot_a_nxt = ev_slot;
               slot_b_nxt = '0;
               fill_nxt   = SDR_FILL_A;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         fill_r   <= SDR_FILL_EMPTY;
         slot_a_r <= '0;
         slot_b_r <= '0;
      end
      else if (i_clk_en)
      begin
         fill_r   <= fill_nxt;
         slot_a_r <= slot_a_nxt;
         slot_b_r <= slot_b_nxt;
      end
   end

   //===========================================================================
   // Read data

   always_comb
   begin
      rd_data_nxt = 32'h00000000;
      if (rd_cnt)
      begin
         rd_data_nxt = 32'(cnt_r);
      end
      else if (rd_pend)
      begin
         rd_data_nxt = pack_pending(slot_a_r, slot_b_r);
      end
      else if (rd_mask)
      begin
         rd_data_nxt[`SDR_MASK_BIT] = mask_r;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rd_data_r <= 32'h00000000;
      end
      else if (i_clk_en)
      begin
         rd_data_r <= rd_data_nxt;
      end
   end

   //===========================================================================
   // Interrupt output

   always_comb
   begin
      irq_nxt = (slot_a_nxt.valid || slot_b_nxt.valid) && !mask_nxt;
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         irq_r <= 1'b0;
      end
      else if (i_clk_en)
      begin
         irq_r <= irq_nxt;
      end
   end

   //===========================================================================
   // Outputs

   assign o_rd_data = rd_data_r;
   assign o_irq     = irq_r;

endmodule

/* include/sdr_params.svh */
// Register offsets, field positions, reset values and widths of drop reporting
`ifndef SDR_PARAMS_SVH
`define SDR_PARAMS_SVH

//==============================================================================
// Widths
`define SDR_ADDR_W          16
`define SDR_DATA_W          32
`define SDR_CNT_W           32

//==============================================================================
// Register offsets
`define SDR_OFS_P2_CNT      16'h1C18
`define SDR_OFS_MASK        16'h1C20
`define SDR_OFS_PEND        16'h1C21

//==============================================================================
// Reset values
`define SDR_RST_P2_CNT      32'h00000000
`define SDR_RST_MASK        1'h1

//==============================================================================
// Field positions
`define SDR_MASK_BIT        0
`define SDR_A_VALID_BIT     0
`define SDR_A_PORT_LSB      1
`define SDR_A_REASON_LSB    3
`define SDR_B_VALID_BIT     7
`define SDR_B_PORT_LSB      8
`define SDR_B_REASON_LSB    10

`endif

/* include/sdr_pkg.sv */
// Types shared by the drop event reporting block
package sdr_pkg;
`include "sdr_params.svh"

   typedef enum logic [3:0]
   {
      SDR_RSN_BCAST_LEVEL = 4'h0,
      SDR_RSN_RED         = 4'h1,
      SDR_RSN_NO_BUF      = 4'h2,
      SDR_RSN_NO_DESC     = 4'h3,
      SDR_RSN_NO_DEST     = 4'h4,
      SDR_RSN_RX_ERR      = 4'h5,
      SDR_RSN_DROP_LEVEL  = 4'h6,
      SDR_RSN_YELLOW      = 4'h9
   } sdr_reason_e;

   typedef enum logic [1:0]
   {
      SDR_PORT0     = 2'h0,
      SDR_PORT1     = 2'h1,
      SDR_PORT2     = 2'h2,
      SDR_PORT_RSVD = 2'h3
   } sdr_port_e;

   typedef enum logic [2:0]
   {
      SDR_FILL_EMPTY = 3'h1,
      SDR_FILL_A     = 3'h2,
      SDR_FILL_AB    = 3'h4
   } sdr_fill_e;

   typedef struct packed
   {
      logic                     wr;
      logic                     rd;
      logic [`SDR_ADDR_W-1:0]   addr;
      logic [`SDR_DATA_W-1:0]   wdata;
   } sdr_bus_s;

   typedef struct packed
   {
      logic                     valid;
      logic [3:0]               reason;
      logic [1:0]               port;
   } sdr_event_s;

   typedef struct packed
   {
      logic                     valid;
      logic [3:0]               reason;
      logic [1:0]               port;
   } sdr_slot_s;

endpackage

/* verif/sdr_drop_chk.sv */
// Assertion checker of the drop event reporting ports
`timescale 1ns/1ps
`include "sdr_params.svh"
module sdr_drop_chk
   import sdr_pkg::*;
#(
   parameter int unsigned CNT_W = 32
)
(
   input wire logic        i_core_clk,
   input wire logic        i_rst,
   input wire logic        i_clk_en,
   input wire sdr_bus_s    i_bus,
   input wire sdr_event_s  i_drop,
   input wire logic [31:0] o_rd_data,
   input wire logic        o_irq
);
   logic mask_r;
   logic mask_nxt;

   //==========================================================================
   // Mask shadow
   always_comb
      mask_nxt = (i_clk_en && i_bus.wr && i_bus.addr == `SDR_OFS_MASK) ? i_bus.wdata[0] : mask_r;
   always_ff @(posedge i_core_clk or posedge i_rst)
      if (i_rst) mask_r <= 1'b1;
      else mask_r <= mask_nxt;

   //==========================================================================
   // Properties
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence s_rd(logic [15:0] a);
      i_clk_en && i_bus.rd && i_bus.addr == a;
   endsequence
   sequence s_quiet;
      !i_drop.valid;
   endsequence
   sequence s_evt;
      i_clk_en && i_drop.valid && i_drop.port != 2'h3 && i_drop.reason inside {[4'h0:4'h6], 4'h9};
   endsequence
   AST_RD_IDLE: assert property (
      $past(i_clk_en) && !$past(i_clk_en && i_bus.rd) |-> o_rd_data == 32'h0)
      else $error("read data not idle");
   AST_MASK_RD: assert property (
      s_rd(`SDR_OFS_MASK) |=> o_rd_data == {31'h0, mask_r}) else $error("mask read wrong");
   AST_IRQ_MASK: assert property (
      mask_r |-> !o_irq) else $error("irq while masked");
   AST_IRQ_SET: assert property (
      s_evt ##1 !mask_r |-> o_irq) else $error("irq missing after event");
   AST_IRQ_CLR: assert property (
      s_rd(`SDR_OFS_PEND) ##0 s_quiet |=> !o_irq) else $error("irq after pending read");
   AST_PEND_CLR: assert property (
      s_rd(`SDR_OFS_PEND) ##0 s_quiet ##1 s_rd(`SDR_OFS_PEND) ##0 s_quiet |=> o_rd_data == 32'h0)
      else $error("pending not cleared");
   AST_CNT_CLR: assert property (
      s_rd(`SDR_OFS_P2_CNT) ##0 s_quiet ##1 s_rd(`SDR_OFS_P2_CNT) ##0 s_quiet |=> o_rd_data == 32'h0)
      else $error("counter not cleared");
   AST_CNT_RANGE: assert property (
      s_rd(`SDR_OFS_P2_CNT) |=> (o_rd_data >> CNT_W) == 32'h0) else $error("counter too wide");
   AST_PEND_LAYOUT: assert property (
      s_rd(`SDR_OFS_PEND) |=> o_rd_data[31:14] == 18'h0 && (!o_rd_data[7] || o_rd_data[0]))
      else $error("pending layout wrong");
   AST_PORT_CODE: assert property (
      s_rd(`SDR_OFS_PEND) |=> (!o_rd_data[0] || o_rd_data[2:1] != 2'h3) &&
         (!o_rd_data[7] || o_rd_data[9:8] != 2'h3)) else $error("reserved port code");
   AST_REASON: assert property (
      s_rd(`SDR_OFS_PEND) |=> (!o_rd_data[0] || o_rd_data[6:3] inside {[4'h0:4'h6], 4'h9}) &&
         (!o_rd_data[7] || o_rd_data[13:10] inside {[4'h0:4'h6], 4'h9}))
      else $error("reserved reason code");
endmodule

/* verif/tb.sv */
// Self-checking bench of the drop event reporting block
`timescale 1ns/1ps
`include "sdr_params.svh"
module tb
   import sdr_pkg::*;
;
   localparam int CW = 4;
   logic        clk = 1'b0;
   logic        rst;
   logic        en;
   logic        irq;
   logic        rd_d = 1'b0;
   sdr_bus_s    bus;
   sdr_event_s  drp;
   logic [31:0] rdat;
   logic [15:0] adr[4] = '{`SDR_OFS_P2_CNT, `SDR_OFS_MASK, `SDR_OFS_PEND, 16'h1C19};
   int          num_errors = 0;
   int          n_compared = 0;
   int unsigned cnt = 0;
   int          k;
   bit          msk = 1'b1;
   int          slots[$];
   logic [31:0] exp_q[$];

   always #10 clk = ~clk;

   sdr_drop_report #(.CNT_W(CW)) i_sdr_drop_report (.i_core_clk(clk), .i_rst(rst),
      .i_clk_en(en), .i_bus(bus), .i_drop(drp), .o_rd_data(rdat), .o_irq(irq));

   //==========================================================================
   // Reference model and checks
   task summarize;
      if (num_errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] pend_word();
      logic [31:0] v;
      v = 32'h0;
      foreach (slots[i]) v[i*7 +: 7] = {slots[i][5:0], 1'b1};
      return v;
   endfunction
   task cyc(input logic e, w, r, input logic [15:0] a, input logic [31:0] d, input logic v,
            input logic [3:0] rs, input logic [1:0] pt);
      logic ok;
      ok = v && pt != 2'h3 && rs inside {[4'h0:4'h6], 4'h9};
      if (e && r)
         exp_q.push_back(a == `SDR_OFS_P2_CNT ? cnt : a == `SDR_OFS_MASK ? {31'h0, msk} :
                         a == `SDR_OFS_PEND ? pend_word() : 32'h0);
      en <= e;
      bus <= '{wr: w, rd: r, addr: a, wdata: d};
      drp <= '{valid: v, reason: rs, port: pt};
      @(posedge clk);
      if (e)
      begin
         if (r && a == `SDR_OFS_P2_CNT) cnt = 0;
         if (r && a == `SDR_OFS_PEND) slots.delete();
         if (w && a == `SDR_OFS_MASK) msk = d[0];
         if (ok && pt == 2'h2 && (rs == 4'h1 || rs == 4'h9) && cnt < 2**CW-1) cnt++;
         if (ok && slots.size() < 2) slots.push_back({rs, pt});
      end
   endtask
   always @(posedge clk) rd_d <= bus.rd & en;
   always @(negedge clk)
      if (!rst)
      begin
         if (rd_d) chk(rdat, exp_q.pop_front());
         chk({31'h0, irq}, {31'h0, slots.size() > 0 && !msk});
      end

   //==========================================================================
   // Scenarios
   initial
   begin
      rst = 1'b1;
      en = 1'b1;
      bus = '0;
      drp = '0;
      void'($urandom(96493));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) cyc(1, 0, 1, adr[i], 0, 0, 0, 0);
      cyc(1, 1, 0, 16'h1C19, '1, 0, 0, 0);
      for (int r = 0; r < 16; r++)
         for (int p = 0; p < 4; p++)
         begin
            cyc(1, 0, 0, 0, 0, 1, 4'(r), 2'(p));
            cyc(1, 0, 1, `SDR_OFS_PEND, 0, 0, 0, 0);
         end
      cyc(1, 1, 0, `SDR_OFS_MASK, 32'hFFFFFFFE, 0, 0, 0);
      cyc(1, 0, 1, `SDR_OFS_MASK, 0, 0, 0, 0);
      repeat (3) cyc(1, 0, 0, 0, 0, 1, 4'h9, 2'h2);
      cyc(1, 0, 1, `SDR_OFS_PEND, 0, 1, 4'h5, 2'h1);
      cyc(1, 0, 1, `SDR_OFS_PEND, 0, 0, 0, 0);
      repeat (20) cyc(1, 0, 0, 0, 0, 1, 4'h1, 2'h2);
      cyc(1, 0, 1, `SDR_OFS_P2_CNT, 0, 0, 0, 0);
      cyc(1, 0, 1, `SDR_OFS_P2_CNT, 0, 1, 4'h9, 2'h2);
      cyc(0, 0, 1, `SDR_OFS_PEND, 0, 1, 4'h1, 2'h2);
      cyc(1, 0, 1, `SDR_OFS_P2_CNT, 0, 0, 0, 0);
      repeat (400)
      begin
         k = $urandom % 4;
         cyc($urandom % 8 != 0, k == 1, k == 2, adr[$urandom % 4], $urandom, 1'($urandom),
             4'($urandom), 2'($urandom));
      end
      cyc(1, 0, 0, 0, 0, 0, 0, 0);
      cyc(1, 0, 0, 0, 0, 0, 0, 0);
      summarize();
   end
   initial
   begin
      #(2000 * 20);
      num_errors++;
      summarize();
   end
endmodule

bind sdr_drop_report sdr_drop_chk #(.CNT_W(CNT_W)) i_sdr_drop_chk (.i_core_clk(i_core_clk),
   .i_rst(i_rst), .i_clk_en(i_clk_en), .i_bus(i_bus), .i_drop(i_drop), .o_rd_data(o_rd_data),
   .o_irq(o_irq));
